/* File: rtl/rsq_pkg.sv */
package rsq_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NRAIL = 12;
  localparam int NWORD = 7;
  localparam int NSTATE = 8;
  localparam int NGPI = 3;
  localparam int VW = 12;
  localparam int TW = 12;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_US = 1000;
  localparam int MS_CYC = MS_US * (CLK_HZ / 1_000_000);
  localparam int SCAN_US = 400;
  localparam int SCAN_CYC = SCAN_US * (CLK_HZ / 1_000_000);
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = SETTLE_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam logic [TW-1:0] MAX_DLY_MS = 12'hCCC;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] GCTRL_OFS = 12'h000;
  localparam logic [11:0] OPER_OFS = 12'h004;
  localparam logic [11:0] GSTAT_OFS = 12'h008;
  localparam logic [11:0] COMMIT_OFS = 12'h00C;
  localparam logic [11:0] SMAP_OFS = 12'h040;
  localparam logic [11:0] SMAP_END = 12'h060;
  localparam logic [11:0] RAIL_OFS = 12'h100;
  localparam logic [11:0] RAIL_END = 12'h280;
  localparam logic [2:0] W_DLY = 3'h0;
  localparam logic [2:0] W_MAX = 3'h1;
  localparam logic [2:0] W_PG = 3'h2;
  localparam logic [2:0] W_UV = 3'h3;
  localparam logic [2:0] W_OV = 3'h4;
  localparam logic [2:0] W_DEP = 3'h5;
  localparam logic [2:0] W_CTL = 3'h6;
  localparam logic [2:0] W_STAT = 3'h7;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int F_LO = 0;
  localparam int F_HI = 16;
  localparam int C_ON_OP = 0;
  localparam int C_ON_PIN = 1;
  localparam int C_ON_PAR = 2;
  localparam int C_ON_GPI = 3;
  localparam int C_OF_OP = 4;
  localparam int C_OF_PIN = 5;
  localparam int C_OF_PAR = 6;
  localparam int C_OF_FLT = 7;
  localparam int C_OF_MST = 8;
  localparam int C_OF_GPI = 9;
  localparam int C_MON = 10;
  localparam int C_IMM = 11;
  localparam int C_RESP = 12;
  localparam int C_OBEY = 14;
  localparam int C_GSEL = 16;
  localparam int C_GVAL = 18;
  localparam int C_SLV = 20;
  localparam int G_AUTO = 0;
  localparam int G_PSEN = 1;
  localparam int S_EN = 0;
  localparam int S_PG = 1;
  localparam int S_FLT = 2;
  localparam int S_WARN = 3;
  localparam int S_ST = 4;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_RESTART = 2'h0;
  localparam logic [1:0] RESP_IMM = 2'h1;
  localparam logic [1:0] RESP_SEQ = 2'h2;
  localparam logic [1:0] RESP_GROUP = 2'h3;

  typedef enum logic [5:0] {
    RS_OFF = 6'h01,
    RS_TOND = 6'h02,
    RS_RAMP = 6'h04,
    RS_ON = 6'h08,
    RS_TOFF = 6'h10,
    RS_FALL = 6'h20
  } rsq_rail_t;
endpackage : rsq_pkg

/* File: rtl/rsq_tick_if.sv */
`timescale 1ns/1ps
interface rsq_tick_if;
  logic ms;
  logic scan;
  modport src (output ms, output scan);
  modport dst (input ms, input scan);
endinterface : rsq_tick_if

/* File: rtl/rsq_tick.sv */
`timescale 1ns/1ps
module rsq_tick #(
  parameter int MS_CYC = rsq_pkg::MS_CYC,
  parameter int SCAN_CYC = rsq_pkg::SCAN_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // ticks
  rsq_tick_if.src tk
);
  import rsq_pkg::*;
  localparam int MSW = $clog2(MS_CYC);
  localparam int SCW = $clog2(SCAN_CYC);

  if (MS_CYC < 2 || SCAN_CYC < 2) begin : g_chk
    $error("rsq_tick: tick periods must be at least two cycles");
  end

  typedef struct packed {
    logic [MSW-1:0] msc;
    logic [SCW-1:0] scc;
    logic ms;
    logic scan;
  } rsq_tick_st_t;

  rsq_tick_st_t s;
  rsq_tick_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.ms = 1'b0;
    next_s.scan = 1'b0;
    // common millisecond base for every rail timer
    if (s.msc == MSW'(MS_CYC - 1)) begin
      next_s.msc = '0;
      next_s.ms = 1'b1;
    end else begin
      next_s.msc = s.msc + 1'b1;
    end
    if (s.scc == SCW'(SCAN_CYC - 1)) begin
      next_s.scc = '0;
      next_s.scan = 1'b1;
    end else begin
      next_s.scc = s.scc + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tk.ms = s.ms;
  assign tk.scan = s.scan;
endmodule : rsq_tick

/* File: rtl/rsq_top.sv */
// Summary of operation
// - drive one enable output per rail, twelve
// - pin or operation command starts sequencing
// - auto-enable ignores command and pin
// - power-good set above on, cleared below off
// - unmonitored rail on after delay plus max
// - unmonitored rail off after off delay plus max
// - selectable turn-on triggers, any combination
// - on and off delays up to 3276 ms
// - selectable turn-off triggers, any combination
// - max turn-on in ms, zero means unlimited on a monitored rail
// - per rail immediate or sequenced off
// - off delay starts on pin, command, fault
// - uv/ov warning and fault checks once regulated
// - per rail fault response, four kinds
// - config commit request to non-volatile store
// - rail fault shuts slave rails, other controllers
// - three inputs select one of eight states
// - state changes honour sequencing dependencies
// - state change rewrites rail operation bit
// - input three is msb, asserted is one
// - sample state inputs after every reset
// - rail voltages checked once per 400 us scan, rail states every clock
`timescale 1ns/1ps
module rsq_top #(
  parameter int MS_CYC = rsq_pkg::MS_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host pins
  input wire logic ctrlPin,
  input wire logic [rsq_pkg::NGPI-1:0] gpi,
  // cascade to other controllers
  input wire logic faultIn,
  output logic faultOut,
  // rails
  input wire logic [rsq_pkg::NRAIL*rsq_pkg::VW-1:0] railVolt,
  output logic [rsq_pkg::NRAIL-1:0] railEn,
  // non-volatile store
  output logic cfgCommit
);
  import rsq_pkg::*;

  if (MS_CYC < SCAN_CYC) begin : g_chk
    $error("rsq_top: millisecond tick shorter than a scan");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NRAIL-1:0][NWORD-1:0][31:0] cfg;
    logic [NSTATE-1:0][NRAIL-1:0] smap;
    logic autoEn;
    logic psEn;
    logic [NRAIL-1:0] op;
    logic [NRAIL-1:0] pg;
    logic [NRAIL-1:0] en;
    logic [NRAIL-1:0] retry;
    logic [NRAIL-1:0] flt;
    logic [NRAIL-1:0] warn;
    logic [NRAIL-1:0] fev;
    logic [NRAIL-1:0] fgrp;
    rsq_rail_t [NRAIL-1:0] st;
    logic [NRAIL-1:0][TW-1:0] tmr;
    logic pinM;
    logic pin;
    logic fiM;
    logic fi;
    logic [NGPI-1:0] gpiM;
    logic [NGPI-1:0] gpiR;
    logic [NGPI-1:0] cand;
    logic [NGPI-1:0] sel;
    logic [3:0] settle;
    logic [1:0] boot;
    logic loaded;
    logic stNew;
    logic fo;
    logic commit;
    logic [31:0] prdata;
  } rsq_state_t;

  rsq_state_t s;
  rsq_state_t next_s;
  rsq_tick_if tk ();

  rsq_tick #(
    .MS_CYC(MS_CYC),
    .SCAN_CYC(SCAN_CYC)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tk(tk)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) &&
             (a == GCTRL_OFS || a == OPER_OFS || a == GSTAT_OFS || a == COMMIT_OFS ||
              (a >= SMAP_OFS && a < SMAP_END) || (a >= RAIL_OFS && a < RAIL_END));
  endfunction : mapped

  function automatic logic [TW-1:0] fld(input logic [31:0] w, input int pos);
    fld = w[pos +: TW];
  endfunction : fld

  function automatic logic [NRAIL-1:0] hitMask(input logic [NRAIL-1:0] src,
                                              input logic [NRAIL-1:0][NRAIL-1:0] slv);
    hitMask = '0;
    for (int i = 0; i < NRAIL; i++) begin
      if (src[i]) begin
        hitMask = hitMask | slv[i];
      end
    end
  endfunction : hitMask

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] c;
    logic [11:0] ro;
    logic [3:0] ri;
    logic [VW-1:0] v;
    logic [NRAIL-1:0] pgEff;
    logic [NRAIL-1:0][NRAIL-1:0] slv;
    logic [NRAIL-1:0] mstHit;
    logic [NRAIL-1:0] grpHit;
    logic [NGPI:0] gAll;
    logic gHit, onSrc, onReq, depOk, offReq, flt, uvF, ovF;
    c = '0;
    ro = paddr - RAIL_OFS;
    ri = ro[8:5];
    v = '0;
    pgEff = '0;
    slv = '0;
    mstHit = '0;
    grpHit = '0;
    gAll = {1'b0, s.gpiR};
    gHit = 1'b0;
    onSrc = 1'b0;
    onReq = 1'b0;
    depOk = 1'b0;
    offReq = 1'b0;
    flt = 1'b0;
    uvF = 1'b0;
    ovF = 1'b0;
    next_s = s;
    next_s.commit = 1'b0;
    next_s.stNew = 1'b0;
    next_s.pinM = ctrlPin;
    next_s.pin = s.pinM;
    next_s.gpiM = gpi;
    next_s.gpiR = s.gpiM;
    next_s.fiM = faultIn;
    next_s.fi = s.fiM;

    // --------------------------------------------------------------
    // register access
    // --------------------------------------------------------------
    // read data is captured in the setup cycle so the access is zero wait
    if (psel && !penable) begin
      next_s.prdata = '0;
      if (paddr == GCTRL_OFS) begin
        next_s.prdata[G_AUTO] = s.autoEn;
        next_s.prdata[G_PSEN] = s.psEn;
      end else if (paddr == OPER_OFS) begin
        next_s.prdata[NRAIL-1:0] = s.op;
      end else if (paddr == GSTAT_OFS) begin
        for (int r = 0; r < NRAIL; r++) begin
          next_s.prdata[r] = (s.st[r] == RS_ON);
        end
        next_s.prdata[F_HI +: NGPI] = s.sel;
      end else if (paddr >= SMAP_OFS && paddr < SMAP_END && paddr[1:0] == 2'h0) begin
        next_s.prdata[NRAIL-1:0] = s.smap[paddr[4:2]];
      end else if (paddr >= RAIL_OFS && paddr < RAIL_END && paddr[1:0] == 2'h0) begin
        if (paddr[4:2] == W_STAT) begin
          next_s.prdata[S_EN] = s.en[ri];
          next_s.prdata[S_PG] = s.pg[ri];
          next_s.prdata[S_FLT] = s.flt[ri];
          next_s.prdata[S_WARN] = s.warn[ri];
          next_s.prdata[S_ST +: 6] = s.st[ri];
        end else begin
          next_s.prdata = s.cfg[ri][paddr[4:2]];
        end
      end
    end
    if (psel && penable && pwrite && mapped(paddr)) begin
      if (paddr == GCTRL_OFS) begin
        next_s.autoEn = pwdata[G_AUTO];
        next_s.psEn = pwdata[G_PSEN];
      end else if (paddr == OPER_OFS) begin
        next_s.op = pwdata[NRAIL-1:0];
      end else if (paddr == COMMIT_OFS) begin
        next_s.commit = pwdata[0];
      end else if (paddr >= SMAP_OFS && paddr < SMAP_END) begin
        next_s.smap[paddr[4:2]] = pwdata[NRAIL-1:0];
      end else if (paddr >= RAIL_OFS && paddr[4:2] == W_STAT) begin
        // clear is applied before the rail loop so a new fault still wins
        if (pwdata[S_FLT]) begin
          next_s.flt[ri] = 1'b0;
        end
        if (pwdata[S_WARN]) begin
          next_s.warn[ri] = 1'b0;
        end
      end else if (paddr >= RAIL_OFS) begin
        // status only takes fault and warning clears: a write there must not land in a rail word
        next_s.cfg[ri][paddr[4:2]] = pwdata;
      end
    end

    // --------------------------------------------------------------
    // pin-selected states
    // --------------------------------------------------------------
    if (s.gpiR != s.cand) begin
      next_s.cand = s.gpiR;
      next_s.settle = '0;
    end else if (s.settle < 4'(SETTLE_CYC)) begin
      next_s.settle = s.settle + 1'b1;
    end
    if (!s.loaded) begin
      // wait until the synchroniser holds the post-reset level
      if (s.boot == 2'h2) begin
        next_s.sel = s.gpiR;
        next_s.cand = s.gpiR;
        next_s.loaded = 1'b1;
        next_s.stNew = 1'b1;
      end else begin
        next_s.boot = s.boot + 1'b1;
      end
    end else if (s.settle == 4'(SETTLE_CYC - 1) && s.cand != s.sel) begin
      // only a code held for the settle time is taken, so skew is ignored
      next_s.sel = s.cand;
      next_s.stNew = 1'b1;
    end
    if (s.stNew && s.psEn) begin
      for (int r = 0; r < NRAIL; r++) begin
        if (s.cfg[r][W_CTL][C_OBEY]) begin
          next_s.op[r] = s.smap[s.sel][r];
        end
      end
    end

    // --------------------------------------------------------------
    // rails
    // --------------------------------------------------------------
    for (int r = 0; r < NRAIL; r++) begin
      pgEff[r] = s.cfg[r][W_CTL][C_MON] ? s.pg[r] : (s.st[r] == RS_ON);
      slv[r] = s.cfg[r][W_CTL][C_SLV +: NRAIL];
    end
    // fault events are taken one cycle late to keep the loop acyclic
    mstHit = hitMask(s.fev, slv) | {NRAIL{s.fi}};
    grpHit = hitMask(s.fgrp, slv);
    next_s.fev = '0;
    next_s.fgrp = '0;

    for (int r = 0; r < NRAIL; r++) begin
      c = s.cfg[r][W_CTL];
      v = railVolt[r*VW +: VW];
      flt = 1'b0;
      uvF = 1'b0;
      ovF = 1'b0;
      if (tk.ms && s.tmr[r] != MAX_DLY_MS) begin
        next_s.tmr[r] = s.tmr[r] + 1'b1;
      end
      if (tk.scan) begin
        if (v >= fld(s.cfg[r][W_PG], F_LO)) begin
          next_s.pg[r] = 1'b1;
        end else if (v < fld(s.cfg[r][W_PG], F_HI)) begin
          next_s.pg[r] = 1'b0;
        end
      end
      gHit = (gAll[c[C_GSEL +: 2]] == c[C_GVAL]);
      onSrc = c[C_ON_OP] | c[C_ON_PIN];
      // auto-enable bypasses both command and pin
      onReq = s.autoEn | (c[C_ON_OP] & s.op[r]) | (c[C_ON_PIN] & s.pin) |
              (!onSrc & (c[C_ON_PAR] | c[C_ON_GPI]));
      depOk = (!c[C_ON_PAR] | &(pgEff | ~fld(s.cfg[r][W_DEP], F_LO))) &
              (!c[C_ON_GPI] | gHit);
      offReq = (!s.autoEn & ((c[C_OF_OP] & !s.op[r]) | (c[C_OF_PIN] & !s.pin))) |
               (c[C_OF_PAR] & |(~pgEff & fld(s.cfg[r][W_DEP], F_HI))) |
               (c[C_OF_MST] & mstHit[r]) | (c[C_OF_GPI] & !gHit);
      if (grpHit[r]) begin
        next_s.retry[r] = 1'b1;
      end
      unique case (s.st[r])
        RS_OFF: begin
          next_s.en[r] = 1'b0;
          if (s.retry[r] || (onReq && depOk && (s.autoEn || c[3:0] != 4'h0))) begin
            next_s.st[r] = RS_TOND;
            next_s.tmr[r] = '0;
            next_s.retry[r] = 1'b0;
          end
        end
        RS_TOND: begin
          if (offReq) begin
            next_s.st[r] = RS_OFF;
          end else if (s.tmr[r] >= fld(s.cfg[r][W_DLY], F_LO)) begin
            next_s.st[r] = RS_RAMP;
            next_s.en[r] = 1'b1;
            next_s.tmr[r] = '0;
          end
        end
        RS_RAMP: begin
          if (c[C_MON] ? s.pg[r] : s.tmr[r] >= fld(s.cfg[r][W_MAX], F_LO)) begin
            next_s.st[r] = RS_ON;
          end else if (c[C_MON] && fld(s.cfg[r][W_MAX], F_LO) != '0 &&
                       s.tmr[r] >= fld(s.cfg[r][W_MAX], F_LO)) begin
            flt = 1'b1;
          end else if (offReq) begin
            next_s.st[r] = c[C_IMM] ? RS_FALL : RS_TOFF;
            next_s.en[r] = !c[C_IMM];
            next_s.tmr[r] = '0;
          end
        end
        RS_ON: begin
          if (tk.scan && c[C_MON]) begin
            uvF = v < fld(s.cfg[r][W_UV], F_HI);
            ovF = v > fld(s.cfg[r][W_OV], F_HI);
            if (v < fld(s.cfg[r][W_UV], F_LO) || v > fld(s.cfg[r][W_OV], F_LO)) begin
              next_s.warn[r] = 1'b1;
            end
          end
          flt = uvF | ovF;
          if (!flt && offReq) begin
            next_s.st[r] = c[C_IMM] ? RS_FALL : RS_TOFF;
            next_s.en[r] = !c[C_IMM];
            next_s.tmr[r] = '0;
          end
        end
        RS_TOFF: begin
          if (s.tmr[r] >= fld(s.cfg[r][W_DLY], F_HI)) begin
            next_s.st[r] = RS_FALL;
            next_s.en[r] = 1'b0;
            next_s.tmr[r] = '0;
          end
        end
        RS_FALL: begin
          next_s.en[r] = 1'b0;
          // a monitored rail may finish early once below power-good-off
          if ((c[C_MON] && !s.pg[r]) || s.tmr[r] >= fld(s.cfg[r][W_MAX], F_HI)) begin
            next_s.st[r] = RS_OFF;
          end
        end
      endcase
      if (flt) begin
        next_s.flt[r] = 1'b1;
        next_s.fev[r] = 1'b1;
        next_s.tmr[r] = '0;
        if (c[C_OF_FLT] || c[C_RESP +: 2] == RESP_SEQ) begin
          next_s.st[r] = RS_TOFF;
        end else if (c[C_RESP +: 2] == RESP_IMM) begin
          next_s.st[r] = RS_OFF;
          next_s.en[r] = 1'b0;
        end else begin
          // restart and group restart both drop the rail, then retry
          next_s.st[r] = RS_FALL;
          next_s.en[r] = 1'b0;
          next_s.retry[r] = 1'b1;
          next_s.fgrp[r] = (c[C_RESP +: 2] == RESP_GROUP);
        end
      end
    end
    next_s.fo = |next_s.fev;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.cfg <= {(NRAIL * NWORD){CFG_RST}};
      s.st <= {NRAIL{RS_OFF}};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign railEn = s.en;
  assign faultOut = s.fo;
  assign cfgCommit = s.commit;
endmodule : rsq_top

/* File: sim/rsq_rail_model.sv */
`timescale 1ns/1ps
module rsq_rail_model import rsq_pkg::*; #(
  parameter int RISE = 50,
  parameter logic [11:0] NOM = 12'h800,
  parameter logic [11:0] HIGH = 12'hF00
) (
  // clock
  input wire logic ref_clk,
  // supply side
  input wire logic [rsq_pkg::NRAIL-1:0] railEn,
  input wire logic [rsq_pkg::NRAIL-1:0] ovReq,
  output logic [rsq_pkg::NRAIL*rsq_pkg::VW-1:0] railVolt
);
  int lvl [NRAIL];
  // supplies ramp up and discharge over RISE clocks, far inside one scan, so the sequencer sees each level change as a step
  initial begin
    railVolt = '0;
    foreach (lvl[r]) lvl[r] = 0;
  end
  always @(posedge ref_clk) begin
    for (int r = 0; r < NRAIL; r++) begin
      if (railEn[r] && lvl[r] < RISE) lvl[r] = lvl[r] + 1;
      if (!railEn[r] && lvl[r] > 0) lvl[r] = lvl[r] - 1;
      railVolt[r*VW+:VW] <= ovReq[r] ? HIGH : VW'(lvl[r] * int'(NOM) / RISE);
    end
  end
endmodule : rsq_rail_model

/* File: sim/rsq_checker.sv */
`timescale 1ns/1ps
module rsq_checker import rsq_pkg::*; #(
  parameter int MS_CYC = rsq_pkg::MS_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pulses
  input wire logic faultOut,
  input wire logic cfgCommit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic cmtWr;
  assign acc = psel && penable;
  assign cmtWr = acc && pwrite && paddr == COMMIT_OFS && pwdata[0];
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_phase: assert property (pslverr |-> acc) else $error("pslverr outside access");
  a_err_align: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned ok");
  a_err_unmapped: assert property (acc && paddr == 12'h010 |-> pslverr)
    else $error("unmapped ok");
  a_err_mapped: assert property (acc && paddr == GSTAT_OFS |-> !pslverr) else $error("gstat err");
  a_err_zero: assert property (acc && pslverr |-> prdata == 32'h0) else $error("err data");
  a_read_held: assert property (acc |=> $stable(prdata)) else $error("prdata moved");
  a_commit_cause: assert property (cmtWr |=> cfgCommit ##1 !cfgCommit)
    else $error("commit pulse");
  a_commit_only: assert property (cfgCommit |-> $past(cmtWr)) else $error("stray commit");
  a_fault_pulse: assert property (faultOut |=> !faultOut) else $error("fault pulse long");
  c_commit: cover property (cfgCommit);
  c_fault: cover property (faultOut);
  c_err: cover property (acc && pslverr);
endmodule : rsq_checker
bind rsq_top rsq_checker #(.MS_CYC(MS_CYC)) rsq_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .faultOut(faultOut),
  .cfgCommit(cfgCommit));

/* File: sim/tb.sv */
`timescale 1ns/1ps
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin err_count++; \
  $display("unexpected %s exp %0h got %0h", n, x, g); end end
module tb;
  import rsq_pkg::*;
  // one ms tick per scan period keeps the run short
  localparam int MS = 4000;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic ctrlPin, faultIn, faultOut, cfgCommit, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] gpi;
  logic [NRAIL*VW-1:0] railVolt;
  logic [NRAIL-1:0] railEn, ovReq;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  int pulses = 0;
  rsq_top #(.MS_CYC(MS)) rsq_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctrlPin(ctrlPin), .gpi(gpi), .faultIn(faultIn),
    .faultOut(faultOut), .railVolt(railVolt), .railEn(railEn), .cfgCommit(cfgCommit));
  rsq_rail_model rsq_rail_model_inst (.ref_clk(ref_clk), .railEn(railEn), .ovReq(ovReq),
    .railVolt(railVolt));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (faultOut === 1'b1) pulses++;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task close_out;
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_en(input int r, input logic v, input int lim);
    n = 0;
    while (railEn[r] !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_en
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    apb(0, GSTAT_OFS, 0);
    `CHK("boot state", 3'h6, rd[18:16])
    apb(0, 12'h1A0, 0);
    `CHK("dly reset", CFG_RST, rd)
    apb(1, RAIL_OFS, 32'h0001_0002);
    apb(0, RAIL_OFS, 0);
    `CHK("dly", 32'h0001_0002, rd)
    apb(0, 12'h010, 0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, rd)
    apb(1, COMMIT_OFS, 32'h1);
    @(posedge ref_clk);
    `CHK("commit", 1'b1, cfgCommit)
  endtask : t_regs
  task t_op;
    apb(1, 12'h118, 32'h11);
    apb(1, 12'h104, 32'h0001_0001);
    apb(1, OPER_OFS, 32'h1);
    wait_en(0, 1'b1, 3 * MS);
    `CHK("on delay", 1'b1, n >= MS - 4 && n <= 2 * MS + 8)
    repeat (2 * MS) @(posedge ref_clk);
    apb(0, 12'h11C, 0);
    `CHK("on state", 6'h08, rd[9:4])
    apb(1, OPER_OFS, 32'h0);
    wait_en(0, 1'b0, 2 * MS);
    `CHK("off delay", 1'b1, n <= MS + 8)
    repeat (2 * MS) @(posedge ref_clk);
    apb(0, 12'h11C, 0);
    `CHK("off state", 6'h01, rd[9:4])
  endtask : t_op
  task t_pin;
    apb(1, 12'h138, 32'h22);
    ctrlPin <= 1'b1;
    wait_en(1, 1'b1, MS + 20);
    `CHK("pin on", 1'b1, railEn[1])
    ctrlPin <= 1'b0;
    wait_en(1, 1'b0, MS + 20);
    `CHK("pin off", 1'b0, railEn[1])
  endtask : t_pin
  task t_mon;
    apb(1, 12'h148, 32'h0600_0700);
    apb(1, 12'h14C, 32'h0400_0500);
    apb(1, 12'h150, 32'h0E80_0E00);
    apb(1, 12'h144, 32'h0000_0002);
    apb(1, 12'h158, 32'h0000_1411);
    apb(1, OPER_OFS, 32'h4);
    wait_en(2, 1'b1, MS + 20);
    `CHK("mon on", 1'b1, railEn[2])
    repeat (2 * SCAN_CYC) @(posedge ref_clk);
    apb(0, 12'h15C, 0);
    `CHK("pg", 1'b1, rd[1])
    ovReq[2] <= 1'b1;
    wait_en(2, 1'b0, MS + SCAN_CYC + 20);
    `CHK("ov off", 1'b0, railEn[2])
    apb(0, 12'h15C, 0);
    `CHK("fault", 1'b1, rd[2])
    `CHK("cascade", 1'b1, pulses > 0)
    ovReq[2] <= 1'b0;
  endtask : t_mon
  task t_state;
    apb(1, GCTRL_OFS, 32'h2);
    apb(1, 12'h054, 32'h8);
    apb(1, 12'h178, 32'h4011);
    gpi <= 3'b101;
    wait_en(3, 1'b1, MS + 40);
    `CHK("state on", 1'b1, railEn[3])
    apb(0, GSTAT_OFS, 0);
    `CHK("state idx", 3'h5, rd[18:16])
    gpi <= 3'b010;
    wait_en(3, 1'b0, MS + 40);
    `CHK("state off", 1'b0, railEn[3])
    apb(0, OPER_OFS, 0);
    `CHK("oper bit", 1'b0, rd[3])
  endtask : t_state
  task t_flt;
    apb(1, 12'h198, 32'h111);
    apb(1, 12'h1A8, 32'h0000_0FFF);
    apb(1, 12'h1A4, 32'h1);
    apb(1, 12'h1B8, 32'h1401);
    apb(1, OPER_OFS, 32'h30);
    wait_en(4, 1'b1, MS + 20);
    `CHK("mst on", 1'b1, railEn[4])
    faultIn <= 1'b1;
    wait_en(4, 1'b0, 20);
    `CHK("mst off", 1'b0, railEn[4])
    faultIn <= 1'b0;
    wait_en(4, 1'b1, MS + 20);
    `CHK("mst back", 1'b1, railEn[4])
    repeat (3 * MS) @(posedge ref_clk);
    apb(0, 12'h1BC, 0);
    `CHK("max on fault", 1'b1, rd[2])
  endtask : t_flt
  initial begin
    {psel, penable, pwrite, ctrlPin, faultIn} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    gpi = 3'b110;
    ovReq = '0;
    rst_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_regs;
    t_op;
    t_pin;
    t_mon;
    t_state;
    t_flt;
    close_out;
  end
  initial begin
    repeat (95000) @(posedge ref_clk);
    err_count++;
    close_out;
  end
endmodule : tb
